// [hw/dsmux_map.svh]
// Register map, field positions and timing counts for the DS3/DS2 mux control
// Contract
// - Enable bit gates change flags onto interrupt
// - Parity mode: no requests, C bits ones
// - DS2 clock rate follows selected mode
// - Code select defines valid C-bit pattern
// - Same code for insert and detect
// - Any reset returns code select to 00
// - Demux alarm forces output tributary ones
// - Mux alarm forces transmit ones, not looped
// - Loopback routes received DS2 into transmit
// - Request insert encodes selected code pattern
// - Seen bit shows declared request state
// - Five M-frames to declare or remove
// - Seen change sets sticky change bit
// - Reading change register clears all bits
// - Interrupt output is active low
`ifndef DSMUX_MAP_SVH
`define DSMUX_MAP_SVH
`define DSMUX_IDX_CONFIG 10'h240
`define DSMUX_IDX_DEMUX_AIS 10'h241
`define DSMUX_IDX_MUX_AIS 10'h242
`define DSMUX_IDX_LOOP_ON 10'h243
`define DSMUX_IDX_REQ_INSERT 10'h244
`define DSMUX_IDX_REQ_SEEN 10'h245
`define DSMUX_IDX_REQ_CHANGED 10'h246
`define DSMUX_IDX_CHG_CLEAR 10'h250
`define DSMUX_IDX_CHG_MASK 10'h251
`define DSMUX_IDX_SOFT_RESET 10'h252
`define DSMUX_CFG_IRQ_EN 0
`define DSMUX_CFG_CBIT 1
`define DSMUX_CFG_CODE_LO 2
`define DSMUX_CFG_CODE_HI 3
`define DSMUX_CFG_WIDTH 4
`define DSMUX_SRST_BIT 0
`define DSMUX_PERSIST_MFRAMES 3'h5
`define DSMUX_RATE_CBIT_E7MHZ 32'h03c242c3
`define DSMUX_RATE_M23_E7MHZ 32'h03c3223a
`define DSMUX_CODE_RESET 2'h0
`endif

// [hw/dsmux_pkg.sv]
// Types and C-bit coding functions for the DS3/DS2 mux control
package dsmux_pkg;
   typedef logic [6:0] dsmux_trib_t;
   typedef logic [1:0] dsmux_code_t;
   typedef logic [2:0] dsmux_cbits_t;

   // C bits held as {C3, C2, C1}
   function automatic logic dsmux_code_match(input dsmux_code_t code,
                                             input dsmux_cbits_t c);
      logic r;
      r = 1'b0;
      unique case (code)
         2'h1: r = (c[0] == c[2]) && (c[0] == c[1]);
         2'h2: r = (c[1] == c[2]) && (c[0] != c[1]);
         default: r = (c[0] == c[1]) && (c[0] != c[2]);
      endcase
      return r;
   endfunction

   function automatic dsmux_cbits_t dsmux_code_make(input dsmux_code_t code,
                                                    input logic s);
      dsmux_cbits_t r;
      r = {s, s, s};
      unique case (code)
         2'h1: r = {s, s, s};
         2'h2: r = {s, s, ~s};
         default: r = {~s, s, s};
      endcase
      return r;
   endfunction
endpackage

// [hw/dsmux_ctrl.sv]
// DS3/DS2 mux control: registers, AIS, loopback, loop request code logic
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "dsmux_map.svh"
module dsmux_ctrl
   import dsmux_pkg::*;
#(
   parameter int TRIBS = 7
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [6:0] rx_line_data,
   input wire logic rx_mframe,
   input wire logic [20:0] rx_cbits,
   output logic [6:0] trib_out_data,
   input wire logic [6:0] trib_in_data,
   input wire logic [6:0] tx_stuff_req,
   output logic [6:0] tx_line_data,
   output logic [20:0] tx_cbits,
   output logic [31:0] ds2_rate_e7mhz,
   output logic irq_out_n,
   output logic irq_source
);
   logic [`DSMUX_CFG_WIDTH-1:0] cfg_reg;
   dsmux_trib_t demux_ais_reg;
   dsmux_trib_t mux_ais_reg;
   dsmux_trib_t loop_on_reg;
   dsmux_trib_t req_insert_reg;
   dsmux_trib_t seen_reg;
   dsmux_trib_t seen_next;
   dsmux_trib_t changed_reg;
   dsmux_trib_t changed_next;
   dsmux_trib_t chg_mask_reg;
   logic [2:0] persist_reg [TRIBS];
   logic [2:0] persist_next [TRIBS];
   logic waitreq_reg;
   logic [31:0] rdata_reg;
   logic [6:0] trib_out_reg;
   logic [6:0] tx_data_reg;
   logic [20:0] tx_cbits_reg;
   logic [20:0] tx_cbits_next;
   logic [31:0] rate_reg;
   logic irq_n_reg;
   logic irq_src_reg;

   wire [9:0] idx = avs_address[11:2];
   wire req = avs_read | avs_write;
   wire accept = req & ~waitreq_reg;
   wire wr_acc = accept & avs_write;
   wire rd_acc = accept & avs_read;
   wire [7:0] wbyte = avs_writedata[7:0];
   wire soft_rst = wr_acc && (idx == `DSMUX_IDX_SOFT_RESET) &&
      wbyte[`DSMUX_SRST_BIT];
   wire wr_cfg = wr_acc && (idx == `DSMUX_IDX_CONFIG);
   wire wr_demux_alarm_insert = wr_acc && (idx == `DSMUX_IDX_DEMUX_AIS);
   wire wr_mux_alarm_insert = wr_acc && (idx == `DSMUX_IDX_MUX_AIS);
   wire wr_loop = wr_acc && (idx == `DSMUX_IDX_LOOP_ON);
   wire wr_ins = wr_acc && (idx == `DSMUX_IDX_REQ_INSERT);
   wire wr_clr = wr_acc && (idx == `DSMUX_IDX_CHG_CLEAR);
   wire wr_mask = wr_acc && (idx == `DSMUX_IDX_CHG_MASK);
   wire rd_chg = rd_acc && (idx == `DSMUX_IDX_REQ_CHANGED);
   wire irq_enable = cfg_reg[`DSMUX_CFG_IRQ_EN];
   wire cbit_parity_enable = cfg_reg[`DSMUX_CFG_CBIT];
   wire dsmux_code_t loop_code_select =
      cfg_reg[`DSMUX_CFG_CODE_HI:`DSMUX_CFG_CODE_LO];

   // Read mux; unmapped addresses read zero
   logic [7:0] rsel;
   always_comb begin
      rsel = 8'h00;
      unique case (idx)
         `DSMUX_IDX_CONFIG: rsel = {4'h0, cfg_reg};
         `DSMUX_IDX_DEMUX_AIS: rsel = {1'b0, demux_ais_reg};
         `DSMUX_IDX_MUX_AIS: rsel = {1'b0, mux_ais_reg};
         `DSMUX_IDX_LOOP_ON: rsel = {1'b0, loop_on_reg};
         `DSMUX_IDX_REQ_INSERT: rsel = {1'b0, req_insert_reg};
         `DSMUX_IDX_REQ_SEEN: rsel = {1'b0, seen_reg};
         `DSMUX_IDX_REQ_CHANGED: rsel = {1'b0, changed_reg};
         `DSMUX_IDX_CHG_MASK: rsel = {1'b0, chg_mask_reg};
         default: rsel = 8'h00;
      endcase
   end

   // One wait state on every access
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         waitreq_reg <= 1'b1;
         rdata_reg <= 32'h0;
      end else begin
         waitreq_reg <= ~(req & waitreq_reg);
         rdata_reg <= (req & waitreq_reg) ? {24'h0, rsel} : 32'h0;
      end
   end

   // Control registers, cleared by either reset except the change mask, which either reset sets to 7f
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_reg <= {`DSMUX_CODE_RESET, 2'h0};
         demux_ais_reg <= 7'h00;
         mux_ais_reg <= 7'h00;
         loop_on_reg <= 7'h00;
         req_insert_reg <= 7'h00;
         chg_mask_reg <= 7'h7f;
      end else if (soft_rst) begin
         cfg_reg <= {`DSMUX_CODE_RESET, 2'h0};
         demux_ais_reg <= 7'h00;
         mux_ais_reg <= 7'h00;
         loop_on_reg <= 7'h00;
         req_insert_reg <= 7'h00;
         chg_mask_reg <= 7'h7f;
      end else begin
         if (wr_cfg) cfg_reg <= wbyte[`DSMUX_CFG_WIDTH-1:0];
         if (wr_demux_alarm_insert) demux_ais_reg <= wbyte[6:0];
         if (wr_mux_alarm_insert) mux_ais_reg <= wbyte[6:0];
         if (wr_loop) loop_on_reg <= wbyte[6:0];
         if (wr_ins) req_insert_reg <= wbyte[6:0];
         if (wr_mask) chg_mask_reg <= wbyte[6:0];
      end
   end

   // Persistence filter, detection off in parity mode
   always_comb begin
      seen_next = seen_reg;
      for (int i = 0; i < TRIBS; i++) begin
         persist_next[i] = persist_reg[i];
         if (cbit_parity_enable) begin
            persist_next[i] = 3'h0;
            seen_next[i] = 1'b0;
         end else if (rx_mframe) begin
            // Same code as insertion
            if (dsmux_code_match(loop_code_select,
                                 rx_cbits[3*i +: 3]) != seen_reg[i]) begin
               if (persist_reg[i] + 3'h1 == `DSMUX_PERSIST_MFRAMES) begin
                  persist_next[i] = 3'h0;
                  seen_next[i] = ~seen_reg[i];
               end else begin
                  persist_next[i] = persist_reg[i] + 3'h1;
               end
            end else begin
               persist_next[i] = 3'h0;
            end
         end
      end
   end

   // Change flags: a new change wins over read or clear
   assign changed_next = (seen_next ^ seen_reg) |
      (changed_reg & ~({7{rd_chg}} | (wr_clr ? wbyte[6:0] : 7'h00)));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         seen_reg <= 7'h00;
         changed_reg <= 7'h00;
         for (int i = 0; i < TRIBS; i++) persist_reg[i] <= 3'h0;
      end else begin
         seen_reg <= seen_next;
         changed_reg <= changed_next;
         for (int i = 0; i < TRIBS; i++) persist_reg[i] <= persist_next[i];
      end
   end

   // Transmit C bits per tributary
   always_comb begin
      tx_cbits_next = 21'h1fffff;
      for (int i = 0; i < TRIBS; i++) begin
         if (cbit_parity_enable) begin
            tx_cbits_next[3*i +: 3] = 3'h7;
         end else if (req_insert_reg[i]) begin
            tx_cbits_next[3*i +: 3] =
               dsmux_code_make(loop_code_select, tx_stuff_req[i]);
         end else begin
            tx_cbits_next[3*i +: 3] = {3{tx_stuff_req[i]}};
         end
      end
   end

   wire [6:0] mux_src = trib_in_data | mux_ais_reg;
   wire [6:0] tx_next = (loop_on_reg & rx_line_data) |
      (~loop_on_reg & mux_src);
   wire [6:0] trib_next = rx_line_data | demux_ais_reg;
   wire irq_pend = irq_enable & |(changed_reg & chg_mask_reg);
   wire [31:0] rate_next = cbit_parity_enable ?
      `DSMUX_RATE_CBIT_E7MHZ : `DSMUX_RATE_M23_E7MHZ;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         trib_out_reg <= 7'h00;
         tx_data_reg <= 7'h00;
         tx_cbits_reg <= 21'h0;
         rate_reg <= `DSMUX_RATE_M23_E7MHZ;
         irq_n_reg <= 1'b1;
         irq_src_reg <= 1'b0;
      end else begin
         trib_out_reg <= trib_next;
         tx_data_reg <= tx_next;
         tx_cbits_reg <= tx_cbits_next;
         rate_reg <= rate_next;
         irq_n_reg <= ~irq_pend;
         irq_src_reg <= irq_pend;
      end
   end

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = waitreq_reg;
   assign trib_out_data = trib_out_reg;
   assign tx_line_data = tx_data_reg;
   assign tx_cbits = tx_cbits_reg;
   assign ds2_rate_e7mhz = rate_reg;
   assign irq_out_n = irq_n_reg;
   assign irq_source = irq_src_reg;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_irq_cause;
      irq_enable && |(changed_reg & chg_mask_reg);
   endsequence

   a_irq_low_pending: assert property (s_irq_cause |=> !irq_out_n && irq_source)
      else $error("interrupt not asserted low while pending");
   a_irq_masked_off: assert property (!irq_enable |=> irq_out_n)
      else $error("interrupt active while disabled");
   a_parity_cbits_ones: assert property (cbit_parity_enable |=>
      tx_cbits == 21'h1fffff)
      else $error("parity mode C bits not all ones");
   a_parity_no_seen: assert property (cbit_parity_enable |=> seen_reg == 7'h0)
      else $error("request seen in parity mode");
   a_rate_mode: assert property (##1 ds2_rate_e7mhz == ($past(cbit_parity_enable)
      ? `DSMUX_RATE_CBIT_E7MHZ : `DSMUX_RATE_M23_E7MHZ))
      else $error("DS2 rate does not follow mode");
   a_insert_pattern: assert property (!cbit_parity_enable && req_insert_reg[0]
      |=> dsmux_code_match($past(loop_code_select), tx_cbits[2:0]))
      else $error("inserted request does not match code");
   a_code_soft_reset: assert property (soft_rst |=> loop_code_select == 2'h0)
      else $error("code select not cleared by soft reset");
   a_demux_alarm: assert property (demux_ais_reg[2] |=> trib_out_data[2])
      else $error("demux alarm not all ones");
   a_loop_route: assert property (loop_on_reg[3] |=>
      tx_line_data[3] == $past(rx_line_data[3]))
      else $error("looped tributary not routed");
   a_mux_alarm: assert property (!loop_on_reg[1] && mux_ais_reg[1] |=>
      tx_line_data[1])
      else $error("mux alarm not all ones");
   a_persist_five: assert property ($changed(seen_reg[0]) && !cbit_parity_enable
      && $past(!cbit_parity_enable) |-> $past(persist_reg[0]) == 3'h4)
      else $error("seen changed before five M-frames");
   a_change_flag: assert property ($changed(seen_reg) |->
      (changed_reg & (seen_reg ^ $past(seen_reg))) == (seen_reg ^ $past(seen_reg)))
      else $error("seen change did not set flag");
   a_read_clears: assert property (rd_chg && seen_next == seen_reg |=>
      changed_reg == 7'h0)
      else $error("change register not cleared by read");

   // Bus handshake steps
   sequence s_bus_open;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   sequence s_bus_ack;
      !avs_waitrequest;
   endsequence

   sequence s_seen_flip;
      $changed(seen_reg[0]);
   endsequence

   sequence s_seen_read;
      avs_read && avs_waitrequest && idx == `DSMUX_IDX_REQ_SEEN;
   endsequence

   a_bus_answer: assert property (
      s_bus_open |=> s_bus_ack)
      else $error("no answer one cycle after request");

   a_ack_one_cycle: assert property (
      s_bus_ack |=> avs_waitrequest)
      else $error("wait request low for more than one cycle");

   a_wait_idle: assert property (
      !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
      else $error("answer without request");

   a_rdata_zero: assert property (
      !((avs_read || avs_write) && avs_waitrequest) |=>
      avs_readdata == 32'h0)
      else $error("read data outside answer cycle");

   a_unused_bit7: assert property (
      avs_readdata[31:7] == 25'h0)
      else $error("unused read bits not zero");

   a_seen_readback: assert property (
      s_seen_read |=> avs_readdata[6:0] == $past(seen_reg))
      else $error("seen register read back wrong");

   a_irq_release: assert property (
      rd_chg && seen_next == seen_reg |=> ##1 irq_out_n)
      else $error("interrupt not released after read");

   a_clear_write: assert property (
      wr_clr && seen_next == seen_reg |=>
      (changed_reg & $past(wbyte[6:0])) == 7'h0)
      else $error("change bits not cleared by write");

   a_change_sticky: assert property (
      changed_reg[0] && !rd_chg && !(wr_clr && wbyte[0]) |=>
      changed_reg[0])
      else $error("change bit lost without clear");

   a_flip_irq: assert property (
      s_seen_flip and irq_enable && chg_mask_reg[0] |=> !irq_out_n)
      else $error("seen change did not raise interrupt");

   a_irq_pair: assert property (
      irq_source != irq_out_n)
      else $error("source flag and interrupt disagree");

   a_persist_reset: assert property (
      rx_mframe && !cbit_parity_enable &&
      dsmux_code_match(loop_code_select, rx_cbits[2:0]) == seen_reg[0]
      |=> persist_reg[0] == 3'h0)
      else $error("persistence count not restarted");

   a_persist_count: assert property (
      rx_mframe && !cbit_parity_enable && persist_reg[0] < 3'h4 &&
      dsmux_code_match(loop_code_select, rx_cbits[2:0]) != seen_reg[0]
      |=> persist_reg[0] == $past(persist_reg[0]) + 3'h1)
      else $error("persistence count did not advance");

   a_seen_needs_frame: assert property (
      !rx_mframe && !cbit_parity_enable |=> $stable(seen_reg))
      else $error("seen changed without M-frame");

   a_parity_persist: assert property (
      cbit_parity_enable |=> persist_reg[0] == 3'h0)
      else $error("persistence count runs in parity mode");

   a_normal_cbits: assert property (
      !cbit_parity_enable && !req_insert_reg[0] |=>
      tx_cbits[2:0] == {3{$past(tx_stuff_req[0])}})
      else $error("normal C-bit coding wrong");

   a_insert_last: assert property (
      !cbit_parity_enable && req_insert_reg[6] |=>
      dsmux_code_match($past(loop_code_select), tx_cbits[20:18]))
      else $error("last tributary request pattern wrong");

   a_trib_copy: assert property (
      !demux_ais_reg[3] |=> trib_out_data[3] == $past(rx_line_data[3]))
      else $error("demux payload not delivered");

   a_mux_path: assert property (
      !loop_on_reg[1] && !mux_ais_reg[1] |=>
      tx_line_data[1] == $past(trib_in_data[1]))
      else $error("mux payload not transmitted");

   a_rate_values: assert property (
      ds2_rate_e7mhz == `DSMUX_RATE_CBIT_E7MHZ ||
      ds2_rate_e7mhz == `DSMUX_RATE_M23_E7MHZ)
      else $error("DS2 rate holds an unknown value");

   a_cfg_write: assert property (
      wr_cfg |=> cfg_reg == $past(wbyte[`DSMUX_CFG_WIDTH-1:0]))
      else $error("configuration write lost");

   a_soft_clears: assert property (
      soft_rst |=> cfg_reg == 4'h0 && loop_on_reg == 7'h00 &&
      req_insert_reg == 7'h00 && chg_mask_reg == 7'h7f)
      else $error("soft reset did not clear controls");
endmodule // dsmux_ctrl

// [testbench/dsmux_line_model.sv]
// Far-side model: DS3 line framer giving M-frames, C bits and line data
`timescale 1ns/1ps
module dsmux_line_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic [2:0] cpat,
   input wire logic [6:0] line_val,
   output logic rx_mframe,
   output logic [20:0] rx_cbits,
   output logic [6:0] rx_line_data
);
   logic [2:0] cnt;
   logic fire;
   assign fire = run && (cnt == 3'h7);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 3'h0;
         rx_mframe <= 1'b0;
         rx_cbits <= 21'h0;
         rx_line_data <= 7'h0;
      end else begin
         cnt <= cnt + 3'h1;
         rx_mframe <= fire;
         // C bits meaningful only with the pulse
         rx_cbits <= fire ? {7{cpat}} : ~{7{cpat}};
         rx_line_data <= line_val;
      end
   end
endmodule // dsmux_line_model

// [testbench/ds3_ds2_mux_loopback_ctrl_tb_top.sv]
// Testbench for the DS3/DS2 mux control block
`timescale 1ns/1ps
`include "dsmux_map.svh"
module ds3_ds2_mux_loopback_ctrl_tb_top;
   import dsmux_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] avs_address = 12'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [6:0] rx_line_data, trib_out_data, tx_line_data;
   logic rx_mframe, irq_out_n, irq_source;
   logic [20:0] rx_cbits, tx_cbits;
   logic [31:0] ds2_rate_e7mhz;
   logic [6:0] trib_in_data = 7'h0;
   logic [6:0] stuff = 7'h0;
   logic [6:0] line_val = 7'h0;
   logic run = 1'b0;
   logic [2:0] cpat = 3'h0;
   logic [7:0] rdv;
   logic [2:0] ins_exp [4] = '{3'h4, 3'h0, 3'h1, 3'h4};
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   always #50 clk = ~clk;
   dsmux_line_model u_far (.clk(clk), .resetn(resetn), .run(run),
      .cpat(cpat), .line_val(line_val), .rx_mframe(rx_mframe),
      .rx_cbits(rx_cbits), .rx_line_data(rx_line_data));
   dsmux_ctrl #(.TRIBS(7)) u_dut (.clk(clk), .resetn(resetn),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rx_line_data(rx_line_data), .rx_mframe(rx_mframe),
      .rx_cbits(rx_cbits), .trib_out_data(trib_out_data),
      .trib_in_data(trib_in_data), .tx_stuff_req(stuff),
      .tx_line_data(tx_line_data), .tx_cbits(tx_cbits),
      .ds2_rate_e7mhz(ds2_rate_e7mhz), .irq_out_n(irq_out_n),
      .irq_source(irq_source));
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic wr, input logic [9:0] idx,
                      input logic [7:0] wd);
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h0, wd};
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic settle();
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic frames(input int n);
      @(posedge clk);
      run <= 1'b1;
      repeat (n) begin
         @(negedge clk);
         while (!rx_mframe) @(negedge clk);
      end
      @(posedge clk);
      run <= 1'b0;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_mismatch++;
         test_done();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      bus(0, `DSMUX_IDX_CONFIG, 8'h0);
      chk("config", rdv, 8'h00);
      chk("rate", ds2_rate_e7mhz, 32'd63119930);
      chk("irq", irq_out_n, 1'b1);
      $display("test reset done");
      bus(1, `DSMUX_IDX_DEMUX_AIS, 8'h01);
      bus(1, `DSMUX_IDX_MUX_AIS, 8'h06);
      bus(1, `DSMUX_IDX_LOOP_ON, 8'h02);
      bus(0, `DSMUX_IDX_MUX_AIS, 8'h0);
      chk("mux ais", rdv, 8'h06);
      settle();
      chk("tx data", tx_line_data, 7'h04);
      chk("trib out", trib_out_data, 7'h01);
      line_val <= 7'h7a;
      trib_in_data <= 7'h10;
      settle();
      chk("tx data", tx_line_data, 7'h16);
      chk("trib out", trib_out_data, 7'h7b);
      $display("test paths done");
      bus(1, `DSMUX_IDX_REQ_INSERT, 8'h01);
      for (int c = 0; c < 4; c++) begin
         bus(1, `DSMUX_IDX_CONFIG, 8'(c << 2));
         settle();
         chk("req cbits", tx_cbits[5:0], {3'h0, ins_exp[c]});
      end
      stuff <= 7'h03;
      settle();
      chk("stuff cbits", tx_cbits[5:0], 6'h3b);
      stuff <= 7'h00;
      $display("test insert done");
      bus(1, `DSMUX_IDX_CONFIG, 8'h00);
      cpat <= 3'h4;
      frames(4);
      bus(0, `DSMUX_IDX_REQ_SEEN, 8'h0);
      chk("seen", rdv, 8'h00);
      frames(1);
      bus(0, `DSMUX_IDX_REQ_SEEN, 8'h0);
      chk("seen", rdv, 8'h7f);
      settle();
      chk("irq masked", irq_out_n, 1'b1);
      bus(1, `DSMUX_IDX_CONFIG, 8'h01);
      settle();
      chk("irq", irq_out_n, 1'b0);
      chk("source", irq_source, 1'b1);
      bus(0, `DSMUX_IDX_REQ_CHANGED, 8'h0);
      chk("changed", rdv, 8'h7f);
      bus(0, `DSMUX_IDX_REQ_CHANGED, 8'h0);
      chk("changed", rdv, 8'h00);
      settle();
      chk("irq", irq_out_n, 1'b1);
      cpat <= 3'h0;
      frames(4);
      bus(0, `DSMUX_IDX_REQ_SEEN, 8'h0);
      chk("seen", rdv, 8'h7f);
      frames(1);
      bus(0, `DSMUX_IDX_REQ_SEEN, 8'h0);
      chk("seen", rdv, 8'h00);
      bus(0, `DSMUX_IDX_REQ_CHANGED, 8'h0);
      chk("changed", rdv, 8'h7f);
      $display("test detect done");
      bus(1, `DSMUX_IDX_CONFIG, 8'h0e);
      cpat <= 3'h4;
      frames(5);
      bus(0, `DSMUX_IDX_REQ_SEEN, 8'h0);
      chk("seen", rdv, 8'h00);
      settle();
      chk("cbits", tx_cbits, 21'h1fffff);
      chk("rate", ds2_rate_e7mhz, 32'd63062723);
      bus(1, `DSMUX_IDX_SOFT_RESET, 8'h01);
      bus(0, `DSMUX_IDX_CONFIG, 8'h0);
      chk("config", rdv, 8'h00);
      bus(0, 10'h3ff, 8'h0);
      chk("unmapped", rdv, 8'h00);
      $display("test parity done");
      test_done();
   end
endmodule // ds3_ds2_mux_loopback_ctrl_tb_top
